//--- jtm_defines.svh
`ifndef JTM_DEFINES_SVH
`define JTM_DEFINES_SVH

// Instruction register
`define JTM_IR_W          4
`define JTM_IR_EXTEST     4'h0
`define JTM_IR_SAMPLE     4'h1
`define JTM_IR_PRELOAD    4'h2
`define JTM_IR_IDCODE     4'h3
`define JTM_IR_HIGHZ      4'h4
`define JTM_IR_CLAMP      4'h5
`define JTM_IR_BYPASS     4'hf
`define JTM_IR_CAPTURE    4'h1

// Boundary cells cover the eight functional GPIO pins beyond the shared five
`define JTM_BSR_W         8

// Identification code, value is arbitrary
`define JTM_IDCODE        32'h0000_0001

// Shared pin positions
`define JTM_PIN_TCK       0
`define JTM_PIN_TMS       1
`define JTM_PIN_TDI       2
`define JTM_PIN_TDO       3
`define JTM_PIN_TRST      4
`define JTM_GPIO_W        5

`endif

//--- jtm_pkg.sv
package jtm_pkg;
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR,
        ST_EX2_IR, ST_UPD_IR
    } jtm_state_e;

    // Boundary-scan view handed to the device core domain
    typedef struct packed {
        logic       test_mode;
        logic       drive_en;
        logic       float_all;
        logic [7:0] drive_val;
    } jtm_core_ctl_s;
endpackage

//--- jtm_tap_fsm.sv
`timescale 1ns/1ps
module jtm_tap_fsm (
    input  wire logic               tck_i,
    input  wire logic               trst_n_i,
    input  wire logic               tms_i,
    output jtm_pkg::jtm_state_e     state_o
);
    import jtm_pkg::*;

    jtm_state_e state;
    jtm_state_e next_state;

    // Standard sixteen-state controller, TMS decides every edge
    always_comb begin
        next_state = ST_RESET;
        case (state)
            ST_RESET:  next_state = tms_i ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_i ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tms_i ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms_i ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  next_state = tms_i ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = tms_i ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms_i ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_i ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tms_i ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms_i ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  next_state = tms_i ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = tms_i ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tms_i ? ST_SEL_DR : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    end

    // Asynchronous reset from the combined test reset
    always_ff @(posedge tck_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign state_o = state;
endmodule

//--- jtm_tap.sv
`timescale 1ns/1ps
`include "jtm_defines.svh"
// Behaviour
// - Select pin low gives shared pins to the test port; core goes non-operational.
// - Boundary-scan port with IDCODE, BYPASS, EXTEST, SAMPLE, PRELOAD, HIGHZ, CLAMP.
// - In scan mode GPIO0..4 carry TCK, TMS, TDI, TDO, TRSTn; else plain GPIO.
// - IDCODE instruction shifts out the fixed identification code.
module jtm_tap (
    input  wire logic                    ref_clk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    scan_mode_select_low_i,
    input  wire logic                    master_reset_pin_i,
    // Test clock arriving on shared pin 0, its own domain
    input  wire logic                    tck_i,
    // Shared pins: input, output, output enable (low drives)
    input  wire logic [4:0]              gpio_in_i,
    output logic [4:0]                   gpio_out_o,
    output logic [4:0]                   gpio_oe_n_o,
    // Core-side general-purpose view
    input  wire logic [4:0]              core_gpio_out_i,
    input  wire logic [4:0]              core_gpio_oe_i,
    output logic [4:0]                   core_gpio_in_o,
    // Functional pins observed and controlled by the boundary register
    input  wire logic [7:0]              core_pin_val_i,
    output jtm_pkg::jtm_core_ctl_s       core_ctl_o,
    output logic                         core_halt_o
);
    import jtm_pkg::*;

    // Pin synchronisers into the reference domain
    logic       sel_m;
    logic       sel_s;
    logic       mr_m;
    logic       mr_s;
    logic [4:0] gin_m;
    logic [4:0] gin_s;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_m <= 1'b1;
            sel_s <= 1'b1;
            mr_m  <= 1'b1;
            mr_s  <= 1'b1;
            gin_m <= 5'h00;
            gin_s <= 5'h00;
        end else begin
            sel_m <= scan_mode_select_low_i;
            sel_s <= sel_m;
            mr_m  <= master_reset_pin_i;
            mr_s  <= mr_m;
            // Pads change at any time, so the core only sees them after three flops
            gin_m <= gpio_in_i;
            gin_s <= gin_m;
        end
    end

    logic scan_active;
    assign scan_active = ~sel_s;

    // Test reset: select pin high or TRSTn low forces the controller to reset
    logic trst_n;
    assign trst_n = ~scan_mode_select_low_i ? gpio_in_i[`JTM_PIN_TRST] : 1'b0;

    // TMS is sampled on TCK, so it is ignored entirely while in reset
    jtm_state_e state;
    jtm_tap_fsm u_fsm (
        .tck_i    (tck_i),
        .trst_n_i (trst_n),
        .tms_i    (gpio_in_i[`JTM_PIN_TMS]),
        .state_o  (state)
    );

    logic tdi;
    assign tdi = gpio_in_i[`JTM_PIN_TDI];

    // Instruction register
    logic [`JTM_IR_W-1:0] ir_sh;
    logic [`JTM_IR_W-1:0] ir;
    always_ff @(posedge tck_i or negedge trst_n) begin
        if (!trst_n) begin
            ir_sh <= `JTM_IR_IDCODE;
        end else if (state == ST_CAP_IR) begin
            ir_sh <= `JTM_IR_CAPTURE;
        end else if (state == ST_SH_IR) begin
            ir_sh <= {tdi, ir_sh[`JTM_IR_W-1:1]};
        end
    end

    // Update on falling edge as the standard asks
    always_ff @(negedge tck_i or negedge trst_n) begin
        if (!trst_n) begin
            ir <= `JTM_IR_IDCODE;
        end else if (state == ST_UPD_IR) begin
            ir <= ir_sh;
        end
    end

    // Decode helpers
    function automatic logic uses_bsr(input logic [`JTM_IR_W-1:0] op);
        uses_bsr = (op == `JTM_IR_EXTEST) || (op == `JTM_IR_SAMPLE) ||
                   (op == `JTM_IR_PRELOAD);
    endfunction

    // Core pin word into the test clock domain; the halted core keeps it still
    logic [`JTM_BSR_W-1:0] pv_m;
    logic [`JTM_BSR_W-1:0] pv_s;
    always_ff @(posedge tck_i or negedge trst_n) begin
        if (!trst_n) begin
            pv_m <= 8'h00;
            pv_s <= 8'h00;
        end else begin
            pv_m <= core_pin_val_i;
            pv_s <= pv_m;
        end
    end

    // Data registers: bypass, id, boundary
    logic        bypass;
    logic [31:0] id_sh;
    logic [`JTM_BSR_W-1:0] bsr_sh;
    logic [`JTM_BSR_W-1:0] bsr_upd;
    logic                  upd_tgl;
    always_ff @(posedge tck_i or negedge trst_n) begin
        if (!trst_n) begin
            bypass <= 1'b0;
            id_sh  <= 32'h0000_0000;
            bsr_sh <= 8'h00;
        end else if (state == ST_CAP_DR) begin
            bypass <= 1'b0;
            id_sh  <= `JTM_IDCODE;
            bsr_sh <= pv_s;
        end else if (state == ST_SH_DR) begin
            bypass <= tdi;
            id_sh  <= {tdi, id_sh[31:1]};
            bsr_sh <= {tdi, bsr_sh[`JTM_BSR_W-1:1]};
        end
    end

    always_ff @(negedge tck_i or negedge trst_n) begin
        if (!trst_n) begin
            bsr_upd <= 8'h00;
            upd_tgl <= 1'b0;
        end else if (state == ST_UPD_DR && uses_bsr(ir) && ir != `JTM_IR_SAMPLE) begin
            bsr_upd <= bsr_sh;
            // Toggle tells the core domain that a new word is waiting
            upd_tgl <= ~upd_tgl;
        end
    end

    // Serial output mux, launched on falling edge
    logic tdo_next;
    always_comb begin
        tdo_next = bypass;
        if (state == ST_SH_IR) begin
            tdo_next = ir_sh[0];
        end else if (ir == `JTM_IR_IDCODE) begin
            tdo_next = id_sh[0];
        end else if (uses_bsr(ir)) begin
            tdo_next = bsr_sh[0];
        end
    end

    logic tdo;
    logic tdo_en;
    always_ff @(negedge tck_i or negedge trst_n) begin
        if (!trst_n) begin
            tdo    <= 1'b0;
            tdo_en <= 1'b0;
        end else begin
            tdo    <= tdo_next;
            tdo_en <= (state == ST_SH_DR) || (state == ST_SH_IR);
        end
    end

    // Instruction effects as levels in the test clock domain
    logic t_drive;
    logic t_float;
    always_ff @(posedge tck_i or negedge trst_n) begin
        if (!trst_n) begin
            t_drive <= 1'b0;
            t_float <= 1'b0;
        end else begin
            t_drive <= (ir == `JTM_IR_EXTEST) || (ir == `JTM_IR_CLAMP);
            t_float <= (ir == `JTM_IR_HIGHZ);
        end
    end

    // Levels into the reference domain; the boundary word is only taken after its
    // toggle has crossed, so a half-written word never reaches the pins
    logic       drv_m;
    logic       drv_s;
    logic       flt_m;
    logic       flt_s;
    logic       tgl_m;
    logic       tgl_s;
    logic       tgl_d;
    logic [7:0] val_s;
    logic tdo_m;
    logic tdo_s;
    logic tdoe_m;
    logic tdoe_s;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drv_m  <= 1'b0;
            drv_s  <= 1'b0;
            flt_m  <= 1'b0;
            flt_s  <= 1'b0;
            tgl_m  <= 1'b0;
            tgl_s  <= 1'b0;
            tgl_d  <= 1'b0;
            val_s  <= 8'h00;
            tdo_m  <= 1'b0;
            tdo_s  <= 1'b0;
            tdoe_m <= 1'b0;
            tdoe_s <= 1'b0;
        end else begin
            drv_m  <= t_drive;
            drv_s  <= drv_m;
            flt_m  <= t_float;
            flt_s  <= flt_m;
            tgl_m  <= upd_tgl;
            tgl_s  <= tgl_m;
            tgl_d  <= tgl_s;
            val_s  <= (tgl_s != tgl_d) ? bsr_upd : val_s;
            tdo_m  <= tdo;
            tdo_s  <= tdo_m;
            tdoe_m <= tdo_en;
            tdoe_s <= tdoe_m;
        end
    end

    // Registered pin and core outputs
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gpio_out_o     <= 5'h00;
            gpio_oe_n_o    <= 5'h1f;
            core_gpio_in_o <= 5'h00;
            core_ctl_o     <= '0;
            core_halt_o    <= 1'b0;
        end else if (scan_active) begin
            gpio_out_o     <= {1'b0, tdo_s, 3'h0};
            gpio_oe_n_o    <= {1'b1, ~tdoe_s, 3'h7};
            core_gpio_in_o <= 5'h00;
            core_ctl_o     <= '{test_mode: 1'b1, drive_en: drv_s,
                                float_all: flt_s, drive_val: val_s};
            core_halt_o    <= 1'b1;
        end else begin
            gpio_out_o     <= core_gpio_out_i;
            gpio_oe_n_o    <= ~core_gpio_oe_i;
            core_gpio_in_o <= gin_s;
            core_ctl_o     <= '0;
            // Stay halted until master reset is seen after leaving scan mode
            core_halt_o    <= core_halt_o & mr_s;
        end
    end
endmodule

//--- jtm_tap_properties.sv
`timescale 1ns/1ps
module jtm_tap_properties (
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  scan_mode_select_low_i,
    input  wire logic                  master_reset_pin_i,
    input  wire logic [4:0]            gpio_in_i,
    input  wire logic [4:0]            gpio_out_o,
    input  wire logic [4:0]            gpio_oe_n_o,
    input  wire logic [4:0]            core_gpio_out_i,
    input  wire logic [4:0]            core_gpio_oe_i,
    input  wire logic [4:0]            core_gpio_in_o,
    input  wire jtm_pkg::jtm_core_ctl_s core_ctl_o,
    input  wire logic                  core_halt_o
);
    import jtm_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    // Steady spells long enough to cover the select synchroniser
    sequence s_plain;
        scan_mode_select_low_i [*6];
    endsequence
    sequence s_scan;
        !scan_mode_select_low_i [*6];
    endsequence
    sequence s_quiet;
        (scan_mode_select_low_i && $stable(core_gpio_out_i) && $stable(core_gpio_oe_i)
            && $stable(gpio_in_i)) [*5];
    endsequence

    a_scan_halts_core: assert property ($fell(scan_mode_select_low_i) |-> ##[1:6] core_halt_o)
        else $error("core not halted after scan entry");
    a_scan_holds_halt: assert property (s_scan |-> core_halt_o && core_ctl_o.test_mode)
        else $error("scan mode without halt or test flag");
    a_scan_frees_pins: assert property (s_scan |-> core_gpio_in_o == 5'h00
        && gpio_oe_n_o[2:0] == 3'h7 && gpio_oe_n_o[4])
        else $error("shared input pad driven in scan mode");
    a_plain_pass_in: assert property (s_plain ##1 s_quiet |-> core_gpio_in_o == gpio_in_i
        && gpio_oe_n_o == ~core_gpio_oe_i)
        else $error("plain pads not passed through");
    a_plain_pass_out: assert property (s_plain ##1 s_quiet |->
        (gpio_out_o & core_gpio_oe_i) == (core_gpio_out_i & core_gpio_oe_i))
        else $error("plain pad drive wrong");
    a_plain_tap_idle: assert property (s_plain |-> !core_ctl_o.test_mode
        && !core_ctl_o.drive_en && !core_ctl_o.float_all)
        else $error("test logic active outside scan mode");
    a_halt_waits_mr: assert property (master_reset_pin_i [*4] ##0 core_halt_o |=> core_halt_o)
        else $error("halt dropped without master reset");
    a_mr_releases: assert property (s_plain ##0 !master_reset_pin_i [*4] |-> ##[0:4] !core_halt_o)
        else $error("master reset did not release halt");
endmodule

bind jtm_tap jtm_tap_properties u_jtm_tap_properties (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scan_mode_select_low_i(scan_mode_select_low_i),
    .master_reset_pin_i(master_reset_pin_i), .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o),
    .gpio_oe_n_o(gpio_oe_n_o), .core_gpio_out_i(core_gpio_out_i),
    .core_gpio_oe_i(core_gpio_oe_i), .core_gpio_in_o(core_gpio_in_o),
    .core_ctl_o(core_ctl_o), .core_halt_o(core_halt_o));

//--- jtm_test_ctrl.sv
`timescale 1ns/1ps
module jtm_test_ctrl #(
    parameter int HALF_NS = 407
) (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    output logic      trst_n_o,
    input  wire logic tdo_i
);
    // Slow test clock so TDO has crossed into the core clock before it is taken
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b1;
    end

    // One test clock; TDO is taken just before the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #(HALF_NS);
        tdo = tdo_i;
        tck_o = 1'b1;
        #(HALF_NS);
        tck_o = 1'b0;
    endtask

    // Pulse the optional test reset while the test clock stands low
    task automatic pulse_reset();
        trst_n_o = 1'b0;
        #(HALF_NS);
        trst_n_o = 1'b1;
        #(HALF_NS);
    endtask

    // From idle into the shift state, move n bits LSB first, update, back to idle
    task automatic shift(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        if (ir)
            step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule

//--- tb_jtm_tap.sv
`timescale 1ns/1ps
`include "jtm_defines.svh"
module tb_jtm_tap;
    import jtm_pkg::*;
    logic          ref_clk, resetn, scan_sel_n, mreset_n, halt, tck, tms, tdi, trst_n, b;
    logic [4:0]    drv, core_out, core_oe, pad, gpio_out, gpio_oe_n, core_in;
    logic [7:0]    pin_val, model_v;
    logic [31:0]   dout;
    logic [3:0]    ops [7] = '{4'hf, 4'h1, 4'h2, 4'h0, 4'h4, 4'h5, 4'h3};
    jtm_core_ctl_s ctl;
    int            num_errors = 0, n_compared = 0, seed = 10;

    // Pad wire: chip drive wins; else controller in scan mode, else bench; TDO pulled up
    assign pad = (~gpio_oe_n & gpio_out)
        | (gpio_oe_n & (scan_sel_n ? drv : {trst_n, 1'b1, tdi, tms, tck}));

    jtm_tap u_jtm_tap (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .scan_mode_select_low_i(scan_sel_n),
        .master_reset_pin_i(mreset_n), .tck_i(pad[0]), .gpio_in_i(pad),
        .gpio_out_o(gpio_out), .gpio_oe_n_o(gpio_oe_n), .core_gpio_out_i(core_out),
        .core_gpio_oe_i(core_oe), .core_gpio_in_o(core_in), .core_pin_val_i(pin_val),
        .core_ctl_o(ctl), .core_halt_o(halt));
    jtm_test_ctrl u_jtm_test_ctrl (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(pad[3]));

    // Core clock
    always #20 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("compared=%0d errors=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic settle();
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // Watchdog well beyond the expected run of about 200 us
    initial begin
        #2_000_000;
        num_errors++;
        conclude();
    end

    initial begin
        ref_clk = 1'b0; resetn = 1'b0; scan_sel_n = 1'b1; mreset_n = 1'b1;
        drv = '0; core_out = '0; core_oe = '0; pin_val = '0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        // Random plain traffic; it also wiggles the clock and mode pads
        repeat (30) begin
            @(posedge ref_clk);
            drv <= 5'($random(seed));
            core_out <= 5'($random(seed));
            core_oe <= 5'($random(seed));
            settle();
            check(core_in, (core_oe & core_out) | (~core_oe & drv));
            check(gpio_oe_n, 5'(~core_oe));
        end
        @(posedge ref_clk);
        core_oe <= 5'h00;
        scan_sel_n <= 1'b0;
        settle();
        @(posedge ref_clk);
        core_oe <= 5'h1f;
        pin_val <= 8'($random(seed));
        model_v = 8'($random(seed));
        settle();
        check(halt, 1'b1);
        check(ctl.test_mode, 1'b1);
        // Test logic left reset on entry, so the ID is selected already
        u_jtm_test_ctrl.step(1'b0, 1'b0, b);
        u_jtm_test_ctrl.shift(1'b0, 32, 32'h0, dout);
        check(dout, `JTM_IDCODE);
        foreach (ops[k]) begin
            u_jtm_test_ctrl.shift(1'b1, 4, 32'(ops[k]), dout);
            check(dout, `JTM_IR_CAPTURE);
            settle();
            case (ops[k])
                4'hf: begin
                    u_jtm_test_ctrl.shift(1'b0, 9, 32'(model_v), dout);
                    check(dout, {model_v, 1'b0});
                end
                4'h1: begin
                    u_jtm_test_ctrl.shift(1'b0, 8, 32'h0, dout);
                    check(dout, pin_val);
                end
                4'h2: u_jtm_test_ctrl.shift(1'b0, 8, 32'(model_v), dout);
                4'h0, 4'h5: check({ctl.drive_en, ctl.drive_val}, {1'b1, model_v});
                4'h4: check(ctl.float_all, 1'b1);
                default: begin
                    u_jtm_test_ctrl.shift(1'b0, 32, 32'h0, dout);
                    check(dout, `JTM_IDCODE);
                end
            endcase
        end
        // Test reset on the shared pad must bring back the ID selection
        u_jtm_test_ctrl.shift(1'b1, 4, 32'h0000_000f, dout);
        check(dout, `JTM_IR_CAPTURE);
        u_jtm_test_ctrl.pulse_reset();
        u_jtm_test_ctrl.step(1'b0, 1'b0, b);
        u_jtm_test_ctrl.shift(1'b0, 32, 32'h0, dout);
        check(dout, `JTM_IDCODE);
        @(posedge ref_clk);
        scan_sel_n <= 1'b1;
        settle();
        check(halt, 1'b1);
        @(posedge ref_clk);
        mreset_n <= 1'b0;
        settle();
        @(posedge ref_clk);
        mreset_n <= 1'b1;
        settle();
        check(halt, 1'b0);
        conclude();
    end
endmodule
